// File: src/pxo_pkg.sv
package pxo_pkg;

  // register byte addresses
  localparam logic [7:0] REG_PHASE_ADJ   = 8'h04;
  localparam logic [7:0] REG_HS_WIDTH    = 8'h07;
  localparam logic [7:0] REG_TEST_CTRL   = 8'h14;
  localparam logic [7:0] REG_MODE_CTRL   = 8'h18;
  localparam logic [7:0] REG_STATUS      = 8'h1C;

  // phase adjust register fields
  localparam int PHASE_LSB    = 3;
  localparam int HS_POL_BIT   = 4;
  // test control field
  localparam int SCAN_EN_BIT  = 2;
  // mode control fields
  localparam int DUAL_BIT     = 0;
  localparam int COAST_POL_BIT = 1;
  localparam int HSIN_POL_BIT = 2;
  localparam int COAST_INT_BIT = 3;

  // reset values
  localparam logic [31:0] PHASE_ADJ_RST = 32'h0000_0080;
  localparam logic [31:0] HS_WIDTH_RST  = 32'h0000_0020;
  localparam logic [31:0] TEST_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_CTRL_RST = 32'h0000_0001;

  // scan chain and phase constants
  localparam int SCAN_LEN    = 48;
  localparam int PHASE_STEPS = 32;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] grn;
    logic [7:0] blu;
  } pxo_pixel_t;

  typedef struct packed {
    pxo_pixel_t a;
    pxo_pixel_t b;
  } pxo_ports_t;

endpackage

// File: src/pxo_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module pxo_sync2 #(
  parameter int W = 1
) (
  // clock
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// File: src/pxo_scan_chain.sv
`timescale 1ns/1ns
`default_nettype none
module pxo_scan_chain #(
  parameter int LEN = 48
) (
  // clock
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           ce,
  // control
  input  wire logic           enable,
  input  wire logic           rise,
  input  wire logic           fall,
  input  wire logic           din,
  // chain
  output logic      [LEN-1:0] chain,
  output logic                dout
);
  // stage LEN-1 is red A bit 7, stage 0 is blue B bit 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain <= '0;
    end else if (ce && enable && rise) begin
      chain <= {din, chain[LEN-1:1]};
    end
  end

  // last stage leaves on the falling scan clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 1'b0;
    end else if (ce && enable && fall) begin
      dout <= chain[0];
    end
  end
endmodule
`default_nettype wire

// File: src/pxo_top.sv
// Summary of operation
// - writing 1 to bit 2 of register 14h enables scan mode
// - scan mode suspends all normal pixel and sync output behaviour
// - 48-stage chain over all data outputs, shifts on rising scan clock
// - first bit shifted in appears on red A bit 7 after one clock
// - after 48 clocks first bit on blue B bit 0, 48th on red A7
// - beyond 48 clocks last stage drives scan out on falling scan edge
// - clock invert at logic 1 inverts the nominal sampling clock
// - sample at leading hsync edge goes to port A, setting phase
// - dual-channel mode alternates following samples between B and A
// - single-channel mode sends all samples to A, B is high impedance
// - in dual-channel mode, output data clock rises between port A data transitions
// - sampling phase adjustable over 360 degrees in 32 steps
// - detect hsync polarity, drive output with polarity from 04H bit 4
// - processed hsync aligned with output data clock and data
// - processed hsync width in pixel clocks equals register 07H
// - coast blocks the pll reference so pixel clock free-runs
// - coast comes from the controller or from internal sync processing
// - coast and hsync input polarity each selectable by a control bit
// - each phase step is 11.25 degrees, hsync out shifted identically
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pxo_top #(
  parameter int DW = 8
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite write address
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // samples from the converters
  input  wire logic [3*DW-1:0]   sample_in,
  input  wire logic              sample_valid,
  // sync and clock control pins
  input  wire logic              hsync_in,
  input  wire logic              coast_in,
  input  wire logic              sample_clock_invert,
  input  wire logic              coast_internal,
  // scan pins
  input  wire logic              scan_clk,
  input  wire logic              scan_in,
  output logic                   scan_out,
  // pixel ports
  output logic [3*DW-1:0]        port_a,
  output logic [3*DW-1:0]        port_b,
  output logic                   port_b_oe,
  output logic                   output_data_clock,
  output logic                   processed_hsync_out,
  // pll and converter controls
  output logic                   pll_ref_gate,
  output logic                   sample_clk_inv,
  output logic [4:0]             sample_phase
);
  localparam int CHAIN = pxo_pkg::SCAN_LEN;

  // ---------------- register file ----------------
  logic [31:0] phase_reg_ff;
  logic [31:0] hs_width_ff;
  logic [31:0] test_ctrl_ff;
  logic [31:0] mode_ctrl_ff;
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [7:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        wr_fire;
  logic        hs_pol_detect_ff;
  logic        scan_mode;

  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pxo_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_ff)
          pxo_pkg::REG_PHASE_ADJ, pxo_pkg::REG_HS_WIDTH,
          pxo_pkg::REG_TEST_CTRL, pxo_pkg::REG_MODE_CTRL: s_axi_bresp <= pxo_pkg::RESP_OKAY;
          default: s_axi_bresp <= pxo_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg_ff <= pxo_pkg::PHASE_ADJ_RST;
      hs_width_ff  <= pxo_pkg::HS_WIDTH_RST;
      test_ctrl_ff <= pxo_pkg::TEST_CTRL_RST;
      mode_ctrl_ff <= pxo_pkg::MODE_CTRL_RST;
    end else if (ce && wr_fire) begin
      unique case (aw_addr_ff)
        pxo_pkg::REG_PHASE_ADJ: phase_reg_ff <= merge(phase_reg_ff, w_data_ff, w_strb_ff) & 32'h0000_00F8;
        pxo_pkg::REG_HS_WIDTH:  hs_width_ff  <= merge(hs_width_ff, w_data_ff, w_strb_ff) & 32'h0000_00FF;
        pxo_pkg::REG_TEST_CTRL: test_ctrl_ff <= merge(test_ctrl_ff, w_data_ff, w_strb_ff) & 32'h0000_0004;
        pxo_pkg::REG_MODE_CTRL: mode_ctrl_ff <= merge(mode_ctrl_ff, w_data_ff, w_strb_ff) & 32'h0000_000F;
        default: ;
      endcase
    end
  end

  // read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pxo_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pxo_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
          pxo_pkg::REG_PHASE_ADJ: s_axi_rdata <= phase_reg_ff;
          pxo_pkg::REG_HS_WIDTH:  s_axi_rdata <= hs_width_ff;
          pxo_pkg::REG_TEST_CTRL: s_axi_rdata <= test_ctrl_ff;
          pxo_pkg::REG_MODE_CTRL: s_axi_rdata <= mode_ctrl_ff;
          pxo_pkg::REG_STATUS:    s_axi_rdata <= {29'h0, pll_ref_gate, scan_mode, hs_pol_detect_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pxo_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- pin synchronisers ----------------
  logic [4:0] pins_s;
  pxo_sync2 #(.W(5)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in ({scan_clk, scan_in, hsync_in, coast_in, sample_clock_invert}),
    .sync_out (pins_s)
  );
  logic scan_clk_s, scan_in_s, hsync_s, coast_s, sample_clock_invert_s;
  assign {scan_clk_s, scan_in_s, hsync_s, coast_s, sample_clock_invert_s} = pins_s;

  assign scan_mode = test_ctrl_ff[pxo_pkg::SCAN_EN_BIT];

  // ---------------- scan chain ----------------
  logic scan_clk_d_ff;
  logic scan_rise, scan_fall;
  logic [CHAIN-1:0] chain;
  logic             chain_out;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_clk_d_ff <= 1'b0;
    end else if (ce) begin
      scan_clk_d_ff <= scan_clk_s;
    end
  end
  assign scan_rise = scan_clk_s && !scan_clk_d_ff;
  assign scan_fall = !scan_clk_s && scan_clk_d_ff;

  pxo_scan_chain #(.LEN(CHAIN)) u_chain (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .enable  (scan_mode),
    .rise    (scan_rise),
    .fall    (scan_fall),
    .din     (scan_in_s),
    .chain   (chain),
    .dout    (chain_out)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_out <= 1'b0;
    end else if (ce) begin
      scan_out <= scan_mode ? chain_out : 1'b0;
    end
  end

  // ---------------- hsync processing ----------------
  logic hsync_d_ff;
  logic hs_active, hs_lead;
  logic [7:0] hs_cnt_ff;
  logic [15:0] hs_hi_ff, hs_lo_ff;

  // polarity detect by comparing high and low durations
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hsync_d_ff       <= 1'b0;
      hs_hi_ff         <= 16'h0000;
      hs_lo_ff         <= 16'h0000;
      hs_pol_detect_ff <= 1'b0;
    end else if (ce) begin
      hsync_d_ff <= hsync_s;
      if (hsync_s) begin
        hs_hi_ff <= (hs_hi_ff == 16'hFFFF) ? hs_hi_ff : hs_hi_ff + 16'h0001;
      end else begin
        hs_lo_ff <= (hs_lo_ff == 16'hFFFF) ? hs_lo_ff : hs_lo_ff + 16'h0001;
      end
      if (hsync_s && !hsync_d_ff) begin
        hs_pol_detect_ff <= hs_hi_ff > hs_lo_ff;
        hs_hi_ff         <= 16'h0000;
        hs_lo_ff         <= 16'h0000;
      end
    end
  end

  // programmed input polarity, inverted when detection finds high longer than low
  assign hs_active = mode_ctrl_ff[pxo_pkg::HSIN_POL_BIT] ^ hsync_s ^ hs_pol_detect_ff;
  assign hs_lead   = hs_active && !(mode_ctrl_ff[pxo_pkg::HSIN_POL_BIT] ^ hsync_d_ff
                                    ^ hs_pol_detect_ff);

  // ---------------- output steering ----------------
  logic       phase_b_ff;
  logic       dual;
  assign dual = mode_ctrl_ff[pxo_pkg::DUAL_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_b_ff        <= 1'b0;
      port_a            <= '0;
      port_b            <= '0;
      port_b_oe         <= 1'b0;
      output_data_clock <= 1'b0;
      processed_hsync_out <= 1'b0;
      hs_cnt_ff         <= 8'h00;
    end else if (ce) begin
      if (scan_mode) begin
        // stage 47 drives red A bit 7
        // stage 0 drives blue B bit 0
        // order A rgb then B rgb
        port_a            <= chain[CHAIN-1 -: 3*DW];
        port_b            <= chain[3*DW-1:0];
        port_b_oe         <= 1'b1;
        output_data_clock <= 1'b0;
        processed_hsync_out <= 1'b0;
      end else if (sample_valid) begin
        // B driven only in dual mode
        port_b_oe <= dual;
        // leading edge sample to port A
        if (hs_lead || !dual || !phase_b_ff) begin
          port_a     <= sample_in;
          phase_b_ff <= dual;
          // clock rises midway through A data
          output_data_clock <= 1'b0;
        end else begin
          port_b            <= sample_in;
          phase_b_ff        <= 1'b0;
          output_data_clock <= 1'b1;
        end
        if (!dual) begin
          // single mode: data clock toggles per sample
          output_data_clock <= !output_data_clock;
        end
        if (hs_lead) begin
          hs_cnt_ff <= hs_width_ff[7:0];
        end else if (hs_cnt_ff != 8'h00) begin
          hs_cnt_ff <= hs_cnt_ff - 8'h01;
        end
        processed_hsync_out <= phase_reg_ff[pxo_pkg::HS_POL_BIT]
                               ^ !(hs_lead ? (hs_width_ff[7:0] != 8'h00) : (hs_cnt_ff > 8'h01));
      end
    end
  end

  // ---------------- pll and clock controls ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_ref_gate   <= 1'b0;
      sample_clk_inv <= 1'b0;
      sample_phase   <= 5'h00;
    end else if (ce) begin
      pll_ref_gate   <= !scan_mode && ((coast_s ^ mode_ctrl_ff[pxo_pkg::COAST_POL_BIT])
                        || (mode_ctrl_ff[pxo_pkg::COAST_INT_BIT] && coast_internal));
      sample_clk_inv <= sample_clock_invert_s;
      sample_phase   <= phase_reg_ff[pxo_pkg::PHASE_LSB +: 5];
    end
  end
endmodule
`default_nettype wire

// File: verification/pxo_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pxo_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // axi handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins
  input wire logic        sample_clock_invert,
  input wire logic        sample_clk_inv,
  input wire logic        coast_in,
  input wire logic        pll_ref_gate,
  input wire logic        scan_clk,
  input wire logic        scan_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_inv_high: assert property (sample_clock_invert [*6] |-> sample_clk_inv)
    else $error("clock invert high not followed");
  a_inv_low: assert property (!sample_clock_invert [*6] |-> !sample_clk_inv)
    else $error("clock invert low not followed");
  a_coast_gate: assert property (coast_in [*6] |-> pll_ref_gate)
    else $error("coast did not block the reference");
  a_scan_fall: assert property ($changed(scan_out) |->
    $past(scan_clk, 5) && !$past(scan_clk, 4))
    else $error("scan out moved without a falling scan clock");
  a_b_answer: assert property (s_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
endmodule
bind pxo_top pxo_chk u_chk (.*);
`default_nettype wire

// File: verification/pxo_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module pxo_far_end (
  // clock
  input  wire logic        aclk,
  // pixel side
  input  wire logic [23:0] port_a,
  input  wire logic        output_data_clock,
  input  wire logic        hsync_in,
  // clock invert back to the block, last port A word to the bench
  output logic             sample_clock_invert,
  output logic [23:0]      last_a
);
  logic [1:0] line_ff = 2'h0;
  logic       inv_ff = 1'b0;
  logic       dclk_ff = 1'b0;
  logic       hs_ff = 1'b0;
  assign sample_clock_invert = inv_ff;
  always @(posedge aclk) begin
    dclk_ff <= output_data_clock;
    if (output_data_clock && !dclk_ff) last_a <= port_a;
  end
  always @(posedge aclk) begin
    hs_ff <= hsync_in;
    if (hsync_in && !hs_ff) line_ff <= line_ff + 2'h1;
    if (hsync_in && !hs_ff && line_ff == 2'h3) inv_ff <= !inv_ff;
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct packed {
    logic [2:0]  k;
    logic [47:0] v;
  } pxo_note_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [23:0] sample_in = 24'h0;
  logic        sample_valid = 1'b0;
  logic        hsync_in = 1'b0;
  logic        coast_in = 1'b0;
  logic        sample_clock_invert;
  logic        coast_internal = 1'b0;
  logic        scan_clk = 1'b0;
  logic        scan_in = 1'b0;
  logic        scan_out;
  logic [23:0] port_a;
  logic [23:0] port_b;
  logic        port_b_oe;
  logic        output_data_clock;
  logic        processed_hsync_out;
  logic        pll_ref_gate;
  logic        sample_clk_inv;
  logic [4:0]  sample_phase;
  logic [23:0] last_a;
  logic        look = 1'b0;
  logic        own = 1'b0;
  logic [97:0] s;
  logic [7:0]  tbl [6] = '{8'h1B, 8'h11, 8'h97, 8'h33, 8'h00, 8'h11};
  string       nm [8] = '{"rdata", "bresp", "ports", "scan_out", "red_a7", "phase", "gate_oe",
                          "line_out"};
  integer      seed = 55503;
  int          miscompares = 0;
  int          checks_done = 0;
  pxo_note_t   notes [$];
  pxo_note_t   n;
  always #25 aclk = ~aclk;
  pxo_top dut (.*);
  pxo_far_end far (.*);
  function automatic logic [47:0] obs(input logic [2:0] k);
    case (k)
      3'h0: obs = {14'h0, s_axi_rresp, s_axi_rdata};
      3'h1: obs = {46'h0, s_axi_bresp};
      3'h2: obs = {port_a, port_b};
      3'h3: obs = {47'h0, scan_out};
      3'h4: obs = {47'h0, port_a[23]};
      3'h5: obs = {43'h0, sample_phase};
      3'h6: obs = {46'h0, pll_ref_gate, port_b_oe};
      default: obs = {22'h0, last_a, output_data_clock, processed_hsync_out};
    endcase
  endfunction
  task automatic check(input logic [2:0] k, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm[k], exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic note(input logic [2:0] k, input logic [47:0] v);
    notes.push_back('{k, v});
  endtask
  task automatic peek(input logic [2:0] k, input logic [47:0] v);
    note(k, v);
    look <= 1'b1;
    @(posedge aclk);
    look <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    note(3'h1, {46'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    // one edge between transfers so no signal is driven twice at once
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    note(3'h0, {14'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // oldest note against each answer
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready) || look) begin
      n = notes.pop_front();
      check(n.k, obs(n.k), n.v);
    end
  end
  // random pixels and a line sync every 80 cycles
  always @(posedge aclk) begin
    if (!own) begin
      sample_in <= 24'($random(seed));
      sample_valid <= 1'($random(seed));
      // coast_in is driven from tbl while this line sync runs
      hsync_in <= (($time / 50) % 80) < 4;
    end
  end
  initial begin
    #1000000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pxo_pkg::REG_PHASE_ADJ, {pxo_pkg::RESP_OKAY, pxo_pkg::PHASE_ADJ_RST});
    rd(pxo_pkg::REG_HS_WIDTH, {pxo_pkg::RESP_OKAY, pxo_pkg::HS_WIDTH_RST});
    rd(pxo_pkg::REG_TEST_CTRL, {pxo_pkg::RESP_OKAY, pxo_pkg::TEST_CTRL_RST});
    rd(pxo_pkg::REG_MODE_CTRL, {pxo_pkg::RESP_OKAY, pxo_pkg::MODE_CTRL_RST});
    rd(8'h30, {pxo_pkg::RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h5, pxo_pkg::RESP_SLVERR);
    wr(pxo_pkg::REG_TEST_CTRL, 32'h4, pxo_pkg::RESP_OKAY);
    s = {2'h0, 32'($random(seed)), 32'($random(seed)), 32'($random(seed))};
    // last bit out is 0, so leaving scan mode moves nothing on scan out
    s[49] = 1'b0;
    scan_in <= s[0];
    for (int i = 0; i <= 96; i++) begin
      scan_clk <= 1'b1;
      if (i == 1) peek(3'h4, {47'h0, s[0]});
      else if (i == 48 || i == 96) peek(3'h2, s[i-48 +: 48]);
      else if (i > 48) peek(3'h3, {47'h0, s[i-48]});
      else @(posedge aclk);
      repeat (3) @(posedge aclk);
      scan_clk <= 1'b0;
      scan_in <= s[i+1];
      repeat (4) @(posedge aclk);
    end
    wr(pxo_pkg::REG_TEST_CTRL, 32'h0, pxo_pkg::RESP_OKAY);
    for (int p = 0; p < pxo_pkg::PHASE_STEPS; p++) begin
      wr(pxo_pkg::REG_PHASE_ADJ, 32'(p) << pxo_pkg::PHASE_LSB, pxo_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      peek(3'h5, 48'(p));
    end
    foreach (tbl[j]) begin
      wr(pxo_pkg::REG_MODE_CTRL, {28'h0, tbl[j][7:4]}, pxo_pkg::RESP_OKAY);
      coast_in <= tbl[j][3];
      coast_internal <= tbl[j][2];
      repeat (8) @(posedge aclk);
      peek(3'h6, {46'h0, tbl[j][1:0]});
    end
    rd(pxo_pkg::REG_MODE_CTRL, {pxo_pkg::RESP_OKAY, 32'h1});
    // dual mode, sync out active high (phase reg F8h), width 32 pixels
    own <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b1;
    hsync_in <= 1'b0;
    repeat (90) @(posedge aclk);
    for (int c = 0; c < 40; c++) begin
      hsync_in <= (c < 4);
      sample_in <= 24'(c);
      if (c == 4) peek(3'h2, 48'h000002_000003);
      else if (c == 34) peek(3'h7, {22'h0, 24'h00001E, 2'h3});
      else if (c == 36) peek(3'h7, {22'h0, 24'h000020, 2'h2});
      else @(posedge aclk);
    end
    close_out();
  end
endmodule
`default_nettype wire
